// ===== common/laser_seq_pkg.sv
// Shared constants and types of the laser output control sequencer.
// Assumes one 200 MHz clock; values are unsigned fixed-point words.
package laser_seq_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ             = 200_000_000;
	localparam int CLK_PERIOD_NS      = 5;
	localparam int MS_CYCLES          = CLK_HZ / 1000;
	localparam int SAFETY_DELAY_MS    = 3000;
	localparam int CONFIRM_TIMEOUT_MS = 3000;
	localparam int SYNC_PULSE_NS      = 10_000;
	localparam int SYNC_PULSE_CYCLES  = SYNC_PULSE_NS / CLK_PERIOD_NS;
	localparam int SYNC_DELAY_MIN_MS  = 5;
	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int VAL_W     = 24;
	localparam int RESP_W    = 16;
	localparam int RESP_FRAC = 8;
	localparam logic [15:0] SYNC_DELAY_RST = 16'h0005;
	localparam logic [15:0] RESP_RST       = 16'h0100;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		LASER_OFF  = 2'b00,
		LASER_WAIT = 2'b01,
		LASER_ON   = 2'b10
	} laser_state_t;
	typedef struct packed {
		logic [15:0] step;
		logic [15:0] count;
		logic [15:0] dwell_ms;
	} scan_cmd_t;
	typedef struct packed {
		logic [VAL_W-1:0] ld_cur;
		logic [VAL_W-1:0] pd_cur;
		logic [VAL_W-1:0] pd_pow;
	} meas_t;
	typedef struct packed {
		logic [VAL_W-1:0] cc;
		logic [VAL_W-1:0] pd_cur;
		logic [VAL_W-1:0] pd_pow;
	} setpts_t;
	typedef struct packed {
		logic [VAL_W-1:0] pd_cur;
		logic [VAL_W-1:0] pd_pow;
	} limits_t;
endpackage

// ===== verilog/laser_output_control_sequencer.sv
// Laser output control: on/off sequencing, setpoints, scan, mode change.
// Assumes command strobes are one-cycle pulses synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module laser_output_control_sequencer #(
	parameter int MS_CYCLES  = laser_seq_pkg::MS_CYCLES,
	parameter int SAFETY_MS  = laser_seq_pkg::SAFETY_DELAY_MS,
	parameter int CONFIRM_MS = laser_seq_pkg::CONFIRM_TIMEOUT_MS
) (
	// Clock and reset
	input  wire logic                         CLK,
	input  wire logic                         SYS_RST,
	// Laser switch and interlock
	input  wire logic                         LASER_ON_REQ,
	input  wire logic                         LASER_OFF_REQ,
	input  wire logic                         INTERLOCK_OPEN,
	// Value and setting writes
	input  wire logic [23:0]                  WR_VALUE,
	input  wire logic                         WR_BIT,
	input  wire logic                         CC_SETPOINT_WR,
	input  wire logic                         PD_CURRENT_WR,
	input  wire logic                         PD_POWER_WR,
	input  wire logic                         PD_CURRENT_LIMIT_WR,
	input  wire logic                         PD_POWER_LIMIT_WR,
	input  wire logic                         SYNC_DELAY_WR,
	input  wire logic                         RANGE_WR,
	input  wire logic                         MOD_ENABLE_WR,
	input  wire logic                         BANDWIDTH_WR,
	input  wire logic                         LOCK_WR,
	input  wire logic                         UNITS_WR,
	input  wire logic                         RESP_WR,
	input  wire logic [15:0]                  RESP,
	input  wire logic [15:0]                  RESP_INV,
	input  wire logic [23:0]                  CC_SETPOINT_MAX,
	// Mode change requests
	input  wire logic                         MODE_WR,
	input  wire logic                         PANEL_MODE_PRESS,
	// Scan
	input  wire logic                         SCAN_START,
	input  wire laser_seq_pkg::scan_cmd_t     SCAN_CMD,
	// Measurements
	input  wire laser_seq_pkg::meas_t         MEAS,
	// Output stage control
	output logic                              SOURCE_ON,
	output logic                              SHUNT_OPEN,
	output logic [23:0]                       REG_TARGET,
	output logic [1:0]                        REG_KIND,
	output logic                              RANGE_HIGH,
	output logic                              MOD_RELAY_CLOSED,
	output logic                              BW_HIGH,
	output logic                              SYNC_OUT_N,
	// Status
	output logic                              MODE_CP,
	output logic                              MODE_LOCK,
	output logic                              POWER_UNITS,
	output logic                              SCAN_ACTIVE,
	output logic                              INTERLOCK_STATE,
	output logic                              CONFIRM_PENDING,
	output logic [15:0]                       SYNC_DELAY,
	output laser_seq_pkg::setpts_t            SETPOINTS,
	output laser_seq_pkg::limits_t            LIMITS,
	output logic                              EXEC_ERROR,
	output logic                              CMD_REFUSED
);
	localparam int SPC = laser_seq_pkg::SYNC_PULSE_CYCLES;

	// Scale by an 8.8 factor; overflow wraps, software keeps it in range
	function automatic logic [23:0] scale(input logic [23:0] v,
		input logic [15:0] k);
		logic [39:0] p;
		p = 40'(v) * 40'(k);
		return p[31:8];
	endfunction

	// ****************************************
	// Time base
	// ****************************************
	laser_seq_pkg::laser_state_t state_ff;
	logic [31:0] div_ff;
	logic        ms_tick;
	logic        laser_on;
	logic        scan_go;
	logic        scan_bad;
	assign ms_tick  = (div_ff == 32'(MS_CYCLES - 1));
	assign laser_on = (state_ff != laser_seq_pkg::LASER_OFF);

	// Restarted by a scan so that steps fall on whole milliseconds
	always_ff @(posedge CLK) begin
		if (SYS_RST || scan_go)
			div_ff <= '0;
		else if (ms_tick)
			div_ff <= '0;
		else
			div_ff <= div_ff + 32'd1;
	end

	// ****************************************
	// Laser on/off sequencing
	// ****************************************
	logic [31:0] safe_cnt_ff;

	// One extra tick so the wait is never short of the delay
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_ff    <= laser_seq_pkg::LASER_OFF;
			safe_cnt_ff <= '0;
			SOURCE_ON   <= 1'b0;
			SHUNT_OPEN  <= 1'b0;
		end else if (INTERLOCK_OPEN || LASER_OFF_REQ) begin
			state_ff   <= laser_seq_pkg::LASER_OFF;
			SOURCE_ON  <= 1'b0;
			SHUNT_OPEN <= 1'b0;
		end else begin
			case (state_ff)
			laser_seq_pkg::LASER_OFF: begin
				safe_cnt_ff <= '0;
				if (LASER_ON_REQ)
					state_ff <= laser_seq_pkg::LASER_WAIT;
			end
			laser_seq_pkg::LASER_WAIT: begin
				if (ms_tick && safe_cnt_ff == 32'(SAFETY_MS)) begin
					state_ff   <= laser_seq_pkg::LASER_ON;
					SOURCE_ON  <= 1'b1;
					SHUNT_OPEN <= 1'b1;
				end else if (ms_tick)
					safe_cnt_ff <= safe_cnt_ff + 32'd1;
			end
			laser_seq_pkg::LASER_ON: ;
			default: state_ff <= laser_seq_pkg::LASER_OFF;
			endcase
		end
	end

	// ****************************************
	// Configuration bits
	// ****************************************
	logic [15:0] resp_ff;
	logic [15:0] inv_ff;
	logic        dly_ok;
	assign dly_ok = WR_VALUE >= 24'(laser_seq_pkg::SYNC_DELAY_MIN_MS)
		&& WR_VALUE[23:16] == 8'h00;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			RANGE_HIGH       <= 1'b0;
			MOD_RELAY_CLOSED <= 1'b0;
			BW_HIGH          <= 1'b0;
			MODE_LOCK        <= 1'b0;
			POWER_UNITS      <= 1'b0;
			SYNC_DELAY       <= laser_seq_pkg::SYNC_DELAY_RST;
			resp_ff          <= laser_seq_pkg::RESP_RST;
			inv_ff           <= laser_seq_pkg::RESP_RST;
			INTERLOCK_STATE  <= 1'b0;
		end else begin
			if (RANGE_WR && !laser_on)
				RANGE_HIGH <= WR_BIT;
			if (MOD_ENABLE_WR)
				MOD_RELAY_CLOSED <= WR_BIT;
			if (BANDWIDTH_WR)
				BW_HIGH <= WR_BIT;
			if (LOCK_WR)
				MODE_LOCK <= WR_BIT;
			if (UNITS_WR)
				POWER_UNITS <= WR_BIT;
			if (SYNC_DELAY_WR && dly_ok)
				SYNC_DELAY <= WR_VALUE[15:0];
			if (RESP_WR) begin
				resp_ff <= RESP;
				inv_ff  <= RESP_INV;
			end
			INTERLOCK_STATE <= INTERLOCK_OPEN;
		end
	end

	// ****************************************
	// Control mode change
	// ****************************************
	logic        locked;
	logic        panel_go;
	logic        remote_go;
	logic        tgt_cp;
	logic        bump;
	logic        cp_err;
	logic        mode_go;
	logic [31:0] conf_cnt_ff;
	assign locked    = MODE_LOCK && laser_on;
	assign panel_go  = PANEL_MODE_PRESS && !locked
		&& (!laser_on || CONFIRM_PENDING);
	assign remote_go = MODE_WR && !locked;
	assign tgt_cp    = MODE_WR ? WR_BIT : !MODE_CP;
	assign bump      = laser_on && (tgt_cp != MODE_CP);
	assign cp_err    = bump && tgt_cp && (POWER_UNITS
		? MEAS.pd_pow > LIMITS.pd_pow
		: MEAS.pd_cur > LIMITS.pd_cur);
	assign mode_go   = (remote_go || panel_go) && !cp_err;

	// First panel press while lit arms a confirmation window
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			CONFIRM_PENDING <= 1'b0;
			conf_cnt_ff     <= '0;
		end else if (panel_go || remote_go || !laser_on || locked) begin
			CONFIRM_PENDING <= 1'b0;
		end else if (PANEL_MODE_PRESS) begin
			CONFIRM_PENDING <= 1'b1;
			conf_cnt_ff     <= '0;
		end else if (CONFIRM_PENDING && ms_tick) begin
			conf_cnt_ff <= conf_cnt_ff + 32'd1;
			if (conf_cnt_ff == 32'(CONFIRM_MS - 1))
				CONFIRM_PENDING <= 1'b0;
		end
	end

	// Remote requests land here on the clock edge after they arrive
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			MODE_CP <= 1'b0;
		else if (mode_go)
			MODE_CP <= tgt_cp;
	end

	// ****************************************
	// Scan engine
	// ****************************************
	logic [23:0]        base;
	logic [23:0]        smax;
	logic signed [33:0] end_val;
	logic [15:0]        step_ff;
	logic [15:0]        left_ff;
	logic [15:0]        dwell_ff;
	logic [15:0]        ms_cnt_ff;
	logic               cp_ff;
	logic               step_now_ff;
	logic               sync_fire;
	assign base    = MODE_CP ? SETPOINTS.pd_cur : SETPOINTS.cc;
	assign smax    = MODE_CP ? LIMITS.pd_cur : CC_SETPOINT_MAX;
	assign end_val = 34'(signed'({1'b0, base}))
		+ 34'($signed(SCAN_CMD.step) * signed'({1'b0, SCAN_CMD.count}));
	assign scan_bad = end_val < 34'sd0
		|| end_val > 34'(signed'({1'b0, smax}))
		|| SCAN_CMD.dwell_ms <= SYNC_DELAY;
	assign scan_go  = SCAN_START && !scan_bad;
	assign sync_fire = SCAN_ACTIVE && ms_tick
		&& (ms_cnt_ff + 16'd1 == SYNC_DELAY);

	// First step follows start at once, then one step per dwell
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SCAN_ACTIVE <= 1'b0;
			step_now_ff <= 1'b0;
			left_ff     <= '0;
			step_ff     <= '0;
			dwell_ff    <= '0;
			ms_cnt_ff   <= '0;
			cp_ff       <= 1'b0;
		end else if (scan_go) begin
			SCAN_ACTIVE <= 1'b1;
			step_now_ff <= (SCAN_CMD.count != 16'h0000);
			left_ff     <= SCAN_CMD.count;
			step_ff     <= SCAN_CMD.step;
			dwell_ff    <= SCAN_CMD.dwell_ms;
			ms_cnt_ff   <= '0;
			cp_ff       <= MODE_CP;
		end else if (SCAN_ACTIVE) begin
			step_now_ff <= 1'b0;
			if (step_now_ff)
				left_ff <= left_ff - 16'd1;
			if (ms_tick && ms_cnt_ff + 16'd1 == dwell_ff) begin
				ms_cnt_ff <= '0;
				if (left_ff != 16'h0000)
					step_now_ff <= 1'b1;
				else
					SCAN_ACTIVE <= 1'b0;
			end else if (ms_tick)
				ms_cnt_ff <= ms_cnt_ff + 16'd1;
		end
	end

	// Sync pulse, low for a fixed count of cycles
	logic [11:0] pcnt_ff;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SYNC_OUT_N <= 1'b1;
			pcnt_ff    <= '0;
		end else if (sync_fire) begin
			SYNC_OUT_N <= 1'b0;
			pcnt_ff    <= 12'(SPC - 1);
		end else if (!SYNC_OUT_N) begin
			if (pcnt_ff == 12'h000)
				SYNC_OUT_N <= 1'b1;
			else
				pcnt_ff <= pcnt_ff - 12'd1;
		end
	end

	// ****************************************
	// Setpoints and photodiode limits
	// ****************************************
	laser_seq_pkg::setpts_t nxt_sp;
	laser_seq_pkg::limits_t nxt_lim;
	logic [15:0] r_nxt;
	logic [15:0] i_nxt;
	logic        pow_master;
	logic        cur_master;
	assign r_nxt = RESP_WR ? RESP : resp_ff;
	assign i_nxt = RESP_WR ? RESP_INV : inv_ff;

	// Later assignments take priority; scan steps win over writes
	always_comb begin
		nxt_sp = SETPOINTS;
		pow_master = PD_POWER_WR || (RESP_WR && POWER_UNITS);
		cur_master = PD_CURRENT_WR || (RESP_WR && !POWER_UNITS);
		if (CC_SETPOINT_WR)
			nxt_sp.cc = WR_VALUE;
		if (PD_CURRENT_WR)
			nxt_sp.pd_cur = WR_VALUE;
		if (PD_POWER_WR)
			nxt_sp.pd_pow = WR_VALUE;
		if (mode_go && bump && tgt_cp) begin
			if (POWER_UNITS)
				nxt_sp.pd_pow = MEAS.pd_pow;
			else
				nxt_sp.pd_cur = MEAS.pd_cur;
			pow_master = POWER_UNITS;
			cur_master = !POWER_UNITS;
		end else if (mode_go && bump)
			nxt_sp.cc = MEAS.ld_cur;
		if (step_now_ff && cp_ff) begin
			nxt_sp.pd_cur = SETPOINTS.pd_cur + 24'($signed(step_ff));
			pow_master = 1'b0;
			cur_master = 1'b1;
		end else if (step_now_ff)
			nxt_sp.cc = SETPOINTS.cc + 24'($signed(step_ff));
		if (pow_master)
			nxt_sp.pd_cur = scale(nxt_sp.pd_pow, r_nxt);
		else if (cur_master)
			nxt_sp.pd_pow = scale(nxt_sp.pd_cur, i_nxt);
	end

	always_comb begin
		nxt_lim = LIMITS;
		if (PD_CURRENT_LIMIT_WR)
			nxt_lim.pd_cur = WR_VALUE;
		if (PD_POWER_LIMIT_WR)
			nxt_lim.pd_pow = WR_VALUE;
		if (PD_POWER_LIMIT_WR || (RESP_WR && POWER_UNITS))
			nxt_lim.pd_cur = scale(nxt_lim.pd_pow, r_nxt);
		else if (PD_CURRENT_LIMIT_WR || RESP_WR)
			nxt_lim.pd_pow = scale(nxt_lim.pd_cur, i_nxt);
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SETPOINTS <= '0;
			LIMITS    <= '0;
		end else begin
			SETPOINTS <= nxt_sp;
			LIMITS    <= nxt_lim;
		end
	end

	// Regulation target follows mode and units one cycle later
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			REG_TARGET <= '0;
			REG_KIND   <= 2'b00;
		end else if (!MODE_CP) begin
			REG_TARGET <= SETPOINTS.cc;
			REG_KIND   <= 2'b00;
		end else if (POWER_UNITS) begin
			REG_TARGET <= SETPOINTS.pd_pow;
			REG_KIND   <= 2'b10;
		end else begin
			REG_TARGET <= SETPOINTS.pd_cur;
			REG_KIND   <= 2'b01;
		end
	end

	// Error and refusal pulses
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			EXEC_ERROR  <= 1'b0;
			CMD_REFUSED <= 1'b0;
		end else begin
			EXEC_ERROR  <= (SCAN_START && scan_bad)
				|| ((remote_go || panel_go) && cp_err);
			CMD_REFUSED <= (LASER_ON_REQ && INTERLOCK_OPEN)
				|| (RANGE_WR && laser_on)
				|| (SYNC_DELAY_WR && !dly_ok)
				|| ((MODE_WR || PANEL_MODE_PRESS) && locked);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_scan_ok;
		SCAN_START && !scan_bad && SCAN_CMD.count != 16'h0000;
	endsequence
	sequence s_first_step;
		SCAN_ACTIVE && step_now_ff ##1 !step_now_ff;
	endsequence

	a_off_now: assert property (LASER_OFF_REQ |=> !SOURCE_ON && !SHUNT_OPEN)
		else $error("laser not off after off request");
	a_il_trip: assert property (INTERLOCK_OPEN |=> !SOURCE_ON)
		else $error("laser on with interlock open");
	a_on_delay: assert property ($rose(SOURCE_ON) |->
		$past(safe_cnt_ff) == 32'(SAFETY_MS) && SHUNT_OPEN)
		else $error("source on before safety delay");
	a_range_hold: assert property (RANGE_WR && laser_on |=>
		$stable(RANGE_HIGH)) else $error("range changed while on");
	a_scan_err: assert property (SCAN_START && scan_bad && !SCAN_ACTIVE
		|=> EXEC_ERROR && !SCAN_ACTIVE) else $error("bad scan accepted");
	a_scan_run: assert property (s_scan_ok |=> s_first_step)
		else $error("scan did not step at once");
	a_sync_time: assert property ($fell(SYNC_OUT_N) |->
		$past(ms_cnt_ff) + 16'd1 == $past(SYNC_DELAY)) else $error("sync late");
	a_dly_min: assert property (SYNC_DELAY >= 16'd5)
		else $error("sync delay below minimum");
	a_mode_lock: assert property ((MODE_WR || PANEL_MODE_PRESS) && locked
		|=> $stable(MODE_CP)) else $error("mode changed while locked");
	a_mod_relay: assert property (!MOD_RELAY_CLOSED && !(MOD_ENABLE_WR
		&& WR_BIT) |=> !MOD_RELAY_CLOSED) else $error("relay closed");
endmodule
`default_nettype wire

// ===== tb/host_model.sv
// Host side stand-in: builds scan orders, inverse responsivity, readings.
// Assumes the bench owns every command strobe and its timing.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Requested values
	input  wire logic [15:0]         step,
	input  wire logic [15:0]         count,
	input  wire logic [15:0]         sync_delay,
	input  wire logic [15:0]         resp,
	// Values handed to the sequencer
	output laser_seq_pkg::scan_cmd_t scan_cmd,
	output logic [15:0]              resp_inv,
	output laser_seq_pkg::meas_t     meas
);
	// ****************************************
	// Host duties
	// ****************************************
	// Dwell two ms above the sync delay, so each pulse fits its step
	assign scan_cmd = '{step: step, count: count,
		dwell_ms: sync_delay + 16'h0002};
	// Inverse in 8.8; a zero responsivity is never sent, it would divide by 0
	assign resp_inv = 16'(32'h0001_0000 / {16'h0000, resp});
	// Fixed readings; pd_cur is above the first current limit the bench programs (0x400) and below the later ones
	assign meas = '{ld_cur: 24'h000123, pd_cur: 24'h000456,
		pd_pow: 24'h000078};
endmodule
`default_nettype wire

// ===== tb/laser_output_control_sequencer_bench.sv
// Self-checking bench of the laser output control sequencer.
// Assumes short ms divider, 3 ms safety and confirm spans, 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module laser_output_control_sequencer_bench;
	// ****************************************
	// Signals
	// ****************************************
	typedef enum int {s_on, s_off, s_cc, s_pdc, s_pdp, s_pdcl, s_pdpl, s_sync_pulse_delay,
		s_range, s_mod, s_bw, s_lock, s_units, s_resp, s_mode, s_panel,
		s_scan} stb_t;
	logic                     clk, sys_rst, ilk, wr_bit, seen_ref, seen_err;
	logic [16:0]              stb;
	logic [23:0]              wr_value, smax, reg_target;
	logic [15:0]              resp, resp_inv, step, count, sync_delay;
	logic [1:0]               reg_kind;
	logic                     source_on, shunt_open, range_high, mod_closed;
	logic                     bw_high, sync_n, mode_cp, mode_lock, units;
	logic                     scan_act, ilk_state, confirm, exec_err, refused;
	laser_seq_pkg::scan_cmd_t scmd;
	laser_seq_pkg::meas_t     meas;
	laser_seq_pkg::setpts_t   setpts;
	laser_seq_pkg::limits_t   limits;
	int                       miscompares, tests_run;
	// ****************************************
	// Design and host
	// ****************************************
	laser_output_control_sequencer #(.MS_CYCLES(10), .SAFETY_MS(3),
		.CONFIRM_MS(3)) i_laser_output_control_sequencer (
		.CLK(clk), .SYS_RST(sys_rst), .LASER_ON_REQ(stb[s_on]),
		.LASER_OFF_REQ(stb[s_off]), .INTERLOCK_OPEN(ilk), .WR_VALUE(wr_value),
		.WR_BIT(wr_bit), .CC_SETPOINT_WR(stb[s_cc]), .PD_CURRENT_WR(stb[s_pdc]),
		.PD_POWER_WR(stb[s_pdp]), .PD_CURRENT_LIMIT_WR(stb[s_pdcl]),
		.PD_POWER_LIMIT_WR(stb[s_pdpl]), .SYNC_DELAY_WR(stb[s_sync_pulse_delay]),
		.RANGE_WR(stb[s_range]), .MOD_ENABLE_WR(stb[s_mod]),
		.BANDWIDTH_WR(stb[s_bw]), .LOCK_WR(stb[s_lock]),
		.UNITS_WR(stb[s_units]), .RESP_WR(stb[s_resp]), .RESP(resp),
		.RESP_INV(resp_inv), .CC_SETPOINT_MAX(smax), .MODE_WR(stb[s_mode]),
		.PANEL_MODE_PRESS(stb[s_panel]), .SCAN_START(stb[s_scan]),
		.SCAN_CMD(scmd), .MEAS(meas), .SOURCE_ON(source_on),
		.SHUNT_OPEN(shunt_open), .REG_TARGET(reg_target), .REG_KIND(reg_kind),
		.RANGE_HIGH(range_high), .MOD_RELAY_CLOSED(mod_closed),
		.BW_HIGH(bw_high), .SYNC_OUT_N(sync_n), .MODE_CP(mode_cp),
		.MODE_LOCK(mode_lock), .POWER_UNITS(units), .SCAN_ACTIVE(scan_act),
		.INTERLOCK_STATE(ilk_state), .CONFIRM_PENDING(confirm),
		.SYNC_DELAY(sync_delay), .SETPOINTS(setpts), .LIMITS(limits),
		.EXEC_ERROR(exec_err), .CMD_REFUSED(refused));
	host_model i_host_model (.step(step), .count(count),
		.sync_delay(sync_delay), .resp(resp), .scan_cmd(scmd),
		.resp_inv(resp_inv), .meas(meas));
	// ****************************************
	// Clock, pulse catcher, helpers
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// One-cycle answers are latched so a check never races the edge;
	// a strobe clears them, since the answer comes one edge after it
	always @(posedge clk) begin
		if (|stb) begin
			seen_ref <= 1'b0;
			seen_err <= 1'b0;
		end else begin
			if (refused === 1'b1) seen_ref <= 1'b1;
			if (exec_err === 1'b1) seen_err <= 1'b1;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input stb_t s);
		@(posedge clk);
		#1 stb[s] = 1'b1;
		tick(1);
		stb[s] = 1'b0;
		tick(1);
	endtask
	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{sys_rst, ilk, wr_bit, stb} = '0;
		{wr_value, smax, step, count} = '0;
		resp = 16'h0100;
		miscompares = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		tick(6);
		sys_rst = 1'b0;
		check("sync delay", 24'h5, sync_delay);
		check("sync idle", 24'h1, sync_n);
		check("relay", 24'h0, mod_closed);
		ilk = 1'b1;
		cmd(s_on);
		check("on refused", 24'h1, seen_ref);
		check("interlock", 24'h1, ilk_state);
		ilk = 1'b0;
		cmd(s_on);
		tick(25);
		check("early source", 24'h0, source_on);
		tick(25);
		check("source", 24'h1, source_on);
		check("shunt", 24'h1, shunt_open);
		$display("test turn_on done");
		wr_bit = 1'b1;
		cmd(s_range);
		check("range refused", 24'h1, seen_ref);
		check("range", 24'h0, range_high);
		cmd(s_bw);
		check("bandwidth", 24'h1, bw_high);
		check("kind cc", 24'h0, reg_kind);
		wr_value = 24'h000400;
		cmd(s_pdcl);
		cmd(s_mode);
		check("cp refused", 24'h1, seen_err);
		check("cp kept", 24'h0, mode_cp);
		wr_value = 24'h00ffff;
		cmd(s_pdcl);
		cmd(s_mode);
		tick(1);
		check("mode cp", 24'h1, mode_cp);
		check("pd load", 24'h000456, setpts.pd_cur);
		check("kind pd", 24'h1, reg_kind);
		check("target pd", 24'h000456, reg_target);
		wr_bit = 1'b0;
		cmd(s_mode);
		check("mode cc", 24'h0, mode_cp);
		check("cc load", 24'h000123, setpts.cc);
		wr_bit = 1'b1;
		cmd(s_lock);
		check("lock", 24'h1, mode_lock);
		cmd(s_mode);
		check("lock refused", 24'h1, seen_ref);
		check("mode kept", 24'h0, mode_cp);
		wr_bit = 1'b0;
		cmd(s_lock);
		cmd(s_panel);
		check("pending", 24'h1, confirm);
		check("no change", 24'h0, mode_cp);
		cmd(s_panel);
		check("confirmed", 24'h1, mode_cp);
		cmd(s_panel);
		tick(50);
		check("expired", 24'h0, confirm);
		check("mode held", 24'h1, mode_cp);
		$display("test mode_change done");
		ilk = 1'b1;
		tick(3);
		check("trip", 24'h0, source_on);
		ilk = 1'b0;
		cmd(s_on);
		tick(55);
		check("on again", 24'h1, source_on);
		cmd(s_off);
		check("off source", 24'h0, source_on);
		check("off shunt", 24'h0, shunt_open);
		$display("test off_trip done");
		cmd(s_mode);
		wr_value = 24'h000004;
		cmd(s_sync_pulse_delay);
		check("delay refused", 24'h1, seen_ref);
		check("delay kept", 24'h5, sync_delay);
		wr_value = 24'h000006;
		cmd(s_sync_pulse_delay);
		check("delay set", 24'h6, sync_delay);
		wr_bit = 1'b1;
		cmd(s_mod);
		check("relay on", 24'h1, mod_closed);
		wr_bit = 1'b0;
		cmd(s_mod);
		check("relay off", 24'h0, mod_closed);
		wr_value = 24'h000064;
		smax = 24'h0000c8;
		cmd(s_cc);
		step = 16'h0032;
		count = 16'h0003;
		cmd(s_scan);
		check("scan error", 24'h1, seen_err);
		check("scan kept", 24'h000064, setpts.cc);
		step = 16'hfff6;
		count = 16'h0002;
		cmd(s_scan);
		check("scan active", 24'h1, scan_act);
		for (int i = 0; i < 300 && sync_n !== 1'b0; i++) tick(1);
		check("sync pulse", 24'h0, sync_n);
		for (int i = 0; i < 400 && scan_act !== 1'b0; i++) tick(1);
		check("scan end", 24'h0, scan_act);
		check("scan value", 24'h000050, setpts.cc);
		check("sync held", 24'h0, sync_n);
		for (int i = 0; i < 2100 && sync_n !== 1'b1; i++) tick(1);
		check("sync high", 24'h1, sync_n);
		$display("test scan done");
		wr_value = 24'h0000c8;
		cmd(s_pdc);
		resp = 16'h0200;
		cmd(s_resp);
		check("ua kept", 24'h0000c8, setpts.pd_cur);
		check("mw new", 24'h000064, setpts.pd_pow);
		wr_bit = 1'b1;
		cmd(s_units);
		resp = 16'h0400;
		cmd(s_resp);
		check("mw kept", 24'h000064, setpts.pd_pow);
		check("ua new", 24'h000190, setpts.pd_cur);
		check("units", 24'h1, units);
		check("limit mw", 24'h007fff, limits.pd_pow);
		check("limit ua", 24'h01fffc, limits.pd_cur);
		cmd(s_mode);
		tick(1);
		check("kind mw", 24'h2, reg_kind);
		check("target mw", 24'h000064, reg_target);
		$display("test responsivity done");
		print_verdict();
	end
endmodule
`default_nettype wire
